// ---- pkg/rscc_pkg.sv ----
// Package: strap field positions, encodings and reset values for the strap capture block
package rscc_pkg;

	// ********************************************************
	// Address pin geometry
	// ********************************************************
	localparam int RSCC_ADDR_W = 20; // Narrow port address pins 20..1
	localparam int RSCC_ADDR_LO = 1;

	// ********************************************************
	// Strap field positions on narrow_port_address
	// ********************************************************
	localparam int RSCC_POS_ENDIAN = 20;
	localparam int RSCC_POS_BOOT_HI = 19;
	localparam int RSCC_POS_BOOT_LO = 18;
	localparam int RSCC_POS_WCLK_HI = 17;
	localparam int RSCC_POS_WCLK_LO = 16;
	localparam int RSCC_POS_NCLK_HI = 15;
	localparam int RSCC_POS_NCLK_LO = 14;
	localparam int RSCC_POS_EEPROM_AUTO_INIT_STRAP = 13;
	localparam int RSCC_POS_CELL = 11;

	// ********************************************************
	// Encodings
	// ********************************************************
	typedef enum logic [1:0]
	{
		RSCC_BOOT_NONE = 2'h0,
		RSCC_BOOT_HOST = 2'h1,
		RSCC_BOOT_ROM8 = 2'h2,
		RSCC_BOOT_RSVD = 2'h3
	} rscc_boot_e;

	typedef enum logic [1:0]
	{
		RSCC_CLK_EXT = 2'h0,
		RSCC_CLK_DIV4 = 2'h1,
		RSCC_CLK_DIV6 = 2'h2,
		RSCC_CLK_RSVD = 2'h3
	} rscc_clk_e;

	// Captured configuration
	typedef struct packed
	{
		logic little_endian;
		rscc_boot_e boot_mode;
		rscc_clk_e wide_clk_sel;
		rscc_clk_e narrow_clk_sel;
		logic eeprom_auto_init;
		logic cell_enable;
		logic serial_one_enable;
		logic boot_reserved;
		logic wide_clk_reserved;
		logic narrow_clk_reserved;
	} rscc_cfg_s;

	// ********************************************************
	// Values held before the first capture (documented defaults)
	// ********************************************************
	localparam rscc_cfg_s RSCC_CFG_RST = '{
		little_endian: 1'b1,
		boot_mode: RSCC_BOOT_ROM8,
		wide_clk_sel: RSCC_CLK_EXT,
		narrow_clk_sel: RSCC_CLK_EXT,
		eeprom_auto_init: 1'b0,
		cell_enable: 1'b0,
		serial_one_enable: 1'b1,
		boot_reserved: 1'b0,
		wide_clk_reserved: 1'b0,
		narrow_clk_reserved: 1'b0
	};

	// Synchroniser depth for pin inputs
	localparam int RSCC_SYNC_STAGES = 3;

endpackage : rscc_pkg

// ---- verilog/rscc_pin_sync.sv ----
// Module: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module rscc_pin_sync
#(
	parameter int WIDTH = 20
)
(
	// Clock and reset
	input wire logic mclk_in,
	input wire logic srst_in,
	// Pin side
	input wire logic [WIDTH-1:0] pin_in,
	// Synchronised side
	output logic [WIDTH-1:0] level_out
);
	import rscc_pkg::*;

	logic [WIDTH-1:0] stage1_r;
	logic [WIDTH-1:0] stage2_r;
	logic [WIDTH-1:0] stage3_r;
	logic [WIDTH-1:0] level_r;

	// Shift chain; first stage is read only by the second
	always_ff @(posedge mclk_in)
	begin
		stage1_r <= pin_in;
		stage2_r <= stage1_r;
		stage3_r <= stage2_r;
	end

	// Per bit, a change counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++)
		begin : g_bit
			always_ff @(posedge mclk_in)
			begin
				if (srst_in)
					level_r[gi] <= 1'b0;
				else if (stage2_r[gi] == stage3_r[gi])
					level_r[gi] <= stage3_r[gi];
			end
		end
	endgenerate

	assign level_out = level_r;

endmodule : rscc_pin_sync

`default_nettype wire

// ---- verilog/rscc_strap_capture.sv ----
// Module: reset-time strap capture on the narrow port address pins
`timescale 1ns/1ns
`default_nettype none

module rscc_strap_capture
(
	// Clock and reset
	input wire logic mclk_in,
	input wire logic srst_in,
	// Narrow port address pins (three signals per pin)
	input wire logic [rscc_pkg::RSCC_ADDR_W:rscc_pkg::RSCC_ADDR_LO] narrow_port_address_in,
	output logic [rscc_pkg::RSCC_ADDR_W:rscc_pkg::RSCC_ADDR_LO] narrow_port_address_out,
	output logic narrow_port_address_oe_out,
	// Address from the memory port logic
	input wire logic [rscc_pkg::RSCC_ADDR_W:rscc_pkg::RSCC_ADDR_LO] mem_address_in,
	input wire logic mem_address_drive_in,
	// Captured configuration
	output rscc_pkg::rscc_cfg_s cfg_out,
	output logic cfg_valid_out
);
	import rscc_pkg::*;

	// ********************************************************
	// Pin synchronisation
	// ********************************************************
	logic [RSCC_ADDR_W-1:0] pins_sync;
	logic [RSCC_ADDR_W:RSCC_ADDR_LO] straps;
	rscc_cfg_s cfg_r;
	rscc_cfg_s cfg_nxt;
	logic valid_r;
	logic in_reset_r;
	// Address word held for the pins
	logic [RSCC_ADDR_W:RSCC_ADDR_LO] addr_r;

	// Pins are asynchronous to mclk, so pass the filter chain
	// Its reset is tied off so the chain keeps settling while reset is held
	rscc_pin_sync #(.WIDTH(RSCC_ADDR_W)) u_sync
	(
		.mclk_in(mclk_in),
		.srst_in(1'b0),
		.pin_in(narrow_port_address_in),
		.level_out(pins_sync)
	);
	assign straps = pins_sync;

	// Reset delayed by one to find the release edge
	always_ff @(posedge mclk_in)
	begin
		in_reset_r <= srst_in;
	end

	// ********************************************************
	// Decode
	// ********************************************************
	// Code 11 is reserved in every two-bit strap field
	function automatic logic is_reserved(input logic [1:0] code);
		is_reserved = (code == 2'h3);
	endfunction : is_reserved

	// Strap decode into configuration
	always_comb
	begin
		cfg_nxt = RSCC_CFG_RST;
		cfg_nxt.little_endian = straps[RSCC_POS_ENDIAN];
		cfg_nxt.boot_mode = rscc_boot_e'(straps[RSCC_POS_BOOT_HI:RSCC_POS_BOOT_LO]);
		cfg_nxt.boot_reserved = is_reserved(straps[RSCC_POS_BOOT_HI:RSCC_POS_BOOT_LO]);
		cfg_nxt.wide_clk_sel = rscc_clk_e'(straps[RSCC_POS_WCLK_HI:RSCC_POS_WCLK_LO]);
		cfg_nxt.wide_clk_reserved = is_reserved(straps[RSCC_POS_WCLK_HI:RSCC_POS_WCLK_LO]);
		cfg_nxt.narrow_clk_sel = rscc_clk_e'(straps[RSCC_POS_NCLK_HI:RSCC_POS_NCLK_LO]);
		cfg_nxt.narrow_clk_reserved = is_reserved(straps[RSCC_POS_NCLK_HI:RSCC_POS_NCLK_LO]);
		cfg_nxt.eeprom_auto_init = straps[RSCC_POS_EEPROM_AUTO_INIT_STRAP];
		cfg_nxt.cell_enable = straps[RSCC_POS_CELL];
		cfg_nxt.serial_one_enable = ~straps[RSCC_POS_CELL];
	end

	// ********************************************************
	// Capture
	// ********************************************************
	// One capture at the first clock after release; later pin activity is ours, so ignore it
	// Valid stays up until reset returns, so mode logic downstream never sees a change
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			valid_r <= 1'b0;
		else if (in_reset_r)
			valid_r <= 1'b1;
	end

	// Config register; defaults shown while in reset
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			cfg_r <= RSCC_CFG_RST;
		else if (in_reset_r && !valid_r)
			cfg_r <= cfg_nxt;
	end

	// Outputs straight from the registers
	assign cfg_out = cfg_r;
	assign cfg_valid_out = valid_r;

	// ********************************************************
	// Pin direction
	// ********************************************************
	// Never drive during reset or before capture, else we would read our own address
	assign narrow_port_address_oe_out = valid_r & mem_address_drive_in;
	// Address word registered so the pins carry a clean value;
	// the cost is one cycle of latency behind the memory port logic
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			addr_r <= '0;
		else
			addr_r <= mem_address_in;
	end

	assign narrow_port_address_out = addr_r;

	// ********************************************************
	// Checks: pin direction
	// ********************************************************
	// Pins stay released through reset so the straps are read, not our own drive
	a_pins_released: assert property (@(posedge mclk_in)
		srst_in |=> !narrow_port_address_oe_out)
		else $error("address pins driven during reset");
	a_oe_release: assert property (@(posedge mclk_in)
		$fell(srst_in) |-> !narrow_port_address_oe_out)
		else $error("address pins driven in the release cycle");
	a_addr_reset: assert property (@(posedge mclk_in)
		srst_in |=> narrow_port_address_out == '0)
		else $error("address word not cleared in reset");
	a_addr_follow: assert property (@(posedge mclk_in)
		!srst_in |=> narrow_port_address_out == $past(mem_address_in))
		else $error("address word does not follow the memory port");

	// ********************************************************
	// Checks: capture and hold
	// ********************************************************
	// Defaults must show while reset is held, before any strap is taken
	a_reset_defaults: assert property (@(posedge mclk_in)
		srst_in |=> cfg_r == RSCC_CFG_RST && !valid_r)
		else $error("defaults not shown in reset");
	a_cfg_stable: assert property (@(posedge mclk_in) disable iff (srst_in)
		valid_r && $past(valid_r) |-> $stable(cfg_r))
		else $error("configuration changed after capture");
	a_capture_once: assert property (@(posedge mclk_in)
		$fell(srst_in) |=> valid_r)
		else $error("capture missed at reset release");
	// Valid must not drop on its own; only reset clears it
	a_valid_hold: assert property (@(posedge mclk_in) disable iff (srst_in)
		$past(valid_r) |-> valid_r)
		else $error("valid dropped without reset");

	// ********************************************************
	// Checks: field maps one cycle after release
	// ********************************************************
	// Each field against the synchronised strap word at the release edge
	// A broken decode or a late capture both show up here
	// Byte order
	a_endian_map: assert property (@(posedge mclk_in) $fell(srst_in) |=>
		cfg_r.little_endian == $past(straps[RSCC_POS_ENDIAN]))
		else $error("endian strap mismatch");

	// Boot source, reserved code flagged
	a_boot_map: assert property (@(posedge mclk_in) $fell(srst_in) |=>
		cfg_r.boot_mode == $past(straps[RSCC_POS_BOOT_HI:RSCC_POS_BOOT_LO]))
		else $error("boot strap mismatch");
	a_boot_rsvd: assert property (@(posedge mclk_in) $fell(srst_in) |=>
		cfg_r.boot_reserved == ($past(straps[RSCC_POS_BOOT_HI:RSCC_POS_BOOT_LO]) == 2'h3))
		else $error("boot reserved flag mismatch");

	// Wide port clock source
	a_wide_clk: assert property (@(posedge mclk_in) $fell(srst_in) |=>
		cfg_r.wide_clk_sel == $past(straps[RSCC_POS_WCLK_HI:RSCC_POS_WCLK_LO]))
		else $error("wide clock strap mismatch");
	a_wclk_rsvd: assert property (@(posedge mclk_in) $fell(srst_in) |=>
		cfg_r.wide_clk_reserved == ($past(straps[RSCC_POS_WCLK_HI:RSCC_POS_WCLK_LO]) == 2'h3))
		else $error("wide clock reserved flag mismatch");

	// Narrow port clock source
	a_narrow_clk: assert property (@(posedge mclk_in) $fell(srst_in) |=>
		cfg_r.narrow_clk_sel == $past(straps[RSCC_POS_NCLK_HI:RSCC_POS_NCLK_LO]))
		else $error("narrow clock strap mismatch");
	a_nclk_rsvd: assert property (@(posedge mclk_in) $fell(srst_in) |=>
		cfg_r.narrow_clk_reserved == ($past(straps[RSCC_POS_NCLK_HI:RSCC_POS_NCLK_LO]) == 2'h3))
		else $error("narrow clock reserved flag mismatch");

	// EEPROM auto-init and the cell interface versus serial port one
	a_eeprom_map: assert property (@(posedge mclk_in) $fell(srst_in) |=>
		cfg_r.eeprom_auto_init == $past(straps[RSCC_POS_EEPROM_AUTO_INIT_STRAP]))
		else $error("auto-init strap mismatch");
	a_cell_map: assert property (@(posedge mclk_in) $fell(srst_in) |=>
		cfg_r.cell_enable == $past(straps[RSCC_POS_CELL]))
		else $error("cell strap mismatch");
	a_serial_map: assert property (@(posedge mclk_in) $fell(srst_in) |=>
		cfg_r.serial_one_enable == !$past(straps[RSCC_POS_CELL]))
		else $error("serial port one strap mismatch");
	a_cell_excl: assert property (@(posedge mclk_in) disable iff (srst_in)
		cfg_r.cell_enable != cfg_r.serial_one_enable)
		else $error("cell and serial port both on or off");

	// ********************************************************
	// Cover points
	// ********************************************************
	// One hit each for byte order, host boot, cell enable and a reserved wide clock code, plus one for the address pins being driven
	c_little: cover property (@(posedge mclk_in) $rose(valid_r) && cfg_r.little_endian);
	c_host_boot: cover property (@(posedge mclk_in) $rose(valid_r) && cfg_r.boot_mode == RSCC_BOOT_HOST);
	c_cell_on: cover property (@(posedge mclk_in) $rose(valid_r) && cfg_r.cell_enable);
	c_drive: cover property (@(posedge mclk_in) narrow_port_address_oe_out);
	c_rsvd_clock: cover property (@(posedge mclk_in) $rose(valid_r) && cfg_r.wide_clk_reserved);

endmodule : rscc_strap_capture

`default_nettype wire

// ---- tb/rscc_board_straps.sv ----
// Board pull resistors on the strap pins
`timescale 1ns/1ns
`default_nettype none

module rscc_board_straps
(
	// Strap pattern and board option
	input wire logic [20:1] strap_in,
	input wire logic pci_en_in,
	// Device drive
	input wire logic [20:1] dev_out_in,
	input wire logic dev_oe_in,
	// Resolved pin levels
	output logic [20:1] pin_out
);
	logic [20:1] pull;

	// Auto-init strap is held low while PCI is off
	always_comb
	begin
		pull = strap_in;
		pull[13] = strap_in[13] & pci_en_in;
	end

	// A released pin falls back to its resistor
	assign pin_out = dev_oe_in ? dev_out_in : pull;
endmodule : rscc_board_straps
`default_nettype wire

// ---- tb/tb_reset_strap_config_capture.sv ----
// Testbench for the reset-time strap capture block
`timescale 1ns/1ns
`default_nettype none

module tb_reset_strap_config_capture;
	import rscc_pkg::*;
	logic mclk_in = 1'b0;
	logic srst_in = 1'b1;
	logic [20:1] strap = 20'h0_0000;
	logic pci_en = 1'b1;
	logic [20:1] mem_addr = 20'h0_0000;
	logic mem_drive = 1'b0;
	logic [20:1] pins;
	logic [20:1] dev_addr;
	logic dev_oe;
	rscc_cfg_s cfg;
	logic cfg_valid;
	int n_errors = 0;
	int n_compared = 0;

	// 250 MHz clock
	always #2 mclk_in = ~mclk_in;

	rscc_board_straps i_board (.strap_in(strap), .pci_en_in(pci_en), .dev_out_in(dev_addr),
		.dev_oe_in(dev_oe), .pin_out(pins));

	rscc_strap_capture i_dut (.mclk_in(mclk_in), .srst_in(srst_in), .narrow_port_address_in(pins),
		.narrow_port_address_out(dev_addr), .narrow_port_address_oe_out(dev_oe),
		.mem_address_in(mem_addr), .mem_address_drive_in(mem_drive), .cfg_out(cfg),
		.cfg_valid_out(cfg_valid));

	task chk_cfg(input string nm, input rscc_cfg_s e, input rscc_cfg_s g);
		n_compared++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk_cfg

	task chk_vec(input string nm, input logic [21:0] e, input logic [21:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk_vec

	// Expected decode of a strap pattern as the pins show it
	function automatic rscc_cfg_s exp_cfg(input logic [20:1] s);
		rscc_cfg_s c;
		c.little_endian = s[RSCC_POS_ENDIAN];
		c.boot_mode = rscc_boot_e'(s[19:18]);
		c.wide_clk_sel = rscc_clk_e'(s[17:16]);
		c.narrow_clk_sel = rscc_clk_e'(s[15:14]);
		c.eeprom_auto_init = s[RSCC_POS_EEPROM_AUTO_INIT_STRAP] & pci_en;
		c.cell_enable = s[RSCC_POS_CELL];
		c.serial_one_enable = ~s[RSCC_POS_CELL];
		c.boot_reserved = (s[19:18] == 2'h3);
		c.wide_clk_reserved = (s[17:16] == 2'h3);
		c.narrow_clk_reserved = (s[15:14] == 2'h3);
		return c;
	endfunction : exp_cfg

	// Reset with straps, release, then disturb the pins
	task scen_capture(input logic [20:1] s);
		strap = s;
		mem_drive = 1'b1;
		mem_addr = ~s;
		srst_in = 1'b1;
		repeat (10) @(negedge mclk_in);
		// Drive request is refused while in reset
		chk_vec("pins in reset", 22'h00_0000, {dev_oe, cfg_valid, dev_addr});
		chk_cfg("cfg in reset", RSCC_CFG_RST, cfg);
		srst_in = 1'b0;
		@(negedge mclk_in);
		chk_cfg("cfg captured", exp_cfg(s), cfg);
		chk_vec("pins driven", {2'b11, ~s}, {dev_oe, cfg_valid, pins});
		// Later pin changes must not reach the config
		strap = ~s;
		mem_drive = 1'b0;
		repeat (6) @(negedge mclk_in);
		chk_cfg("cfg held", exp_cfg(s), cfg);
		chk_vec("pins released", {2'b01, ~s}, {dev_oe, cfg_valid, pins});
	endtask : scen_capture

	task final_report;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report

	// Every code of every field, then auto-init with PCI off
	initial
	begin
		logic [1:0] b;
		for (int i = 0; i < 4; i++)
		begin
			b = 2'(i);
			scen_capture({b[0], b, b, ~b, b[1], 1'b0, b[0], 10'h2A5});
		end
		pci_en = 1'b0;
		scen_capture({1'b1, 2'h2, 2'h0, 2'h0, 1'b1, 1'b0, 1'b0, 10'h0F0});
		final_report();
	end
endmodule : tb_reset_strap_config_capture
`default_nettype wire
